// ==== verilog/clock_generator_control.sv ====
// Clock generator control: protected clock register, prescalers, PLL and clock selector
// How it works
// - Main oscillator stops in stop mode, or stop bit set while on subclock.
// - Prescaler 1 gives peripheral ticks from undivided down to divide by 1024.
// - Prescaler 2 gives divide 1 to 32 ratios to the CPU clock selector.
// - Internal system clock drives memories and interrupt logic, and clock pin.
// - Interval divider turns the oscillator clock into a 32.768 kHz watch tick.
// - PLL passes oscillator clock through or multiplies by four per mode bit.
// - PLL runs while its run bit is set, stops when cleared.
// - Clock register write accepted only right after the protection command write.
// - Clock register resets to 03H, CPU clock main divided by eight.
// - Bit 7 disables the subclock oscillator feedback resistor.
// - Bit 5 disables the main oscillator feedback resistor.
// - Bit 6 zero enables main oscillation, one requests it to stop.
// - Main oscillator keeps running until the CPU has moved to subclock.
// - Bit 4 is read-only status: 0 main clock, 1 subclock.
// - Select field maps 0-5 to divide 1..32, 011x prohibited, 1xxx subclock.
// - Switch to subclock and status update finish within one subclock period.
// - Return to main clock finishes within one subclock period.
// - Wait access on subclock with no main clock stalls until reset.
// - Clock pin follows system clock while operable, low while stopped.
`timescale 1ns/1ps
`include "clock_generator_control_cfg.svh"

module clock_generator_control #(
    parameter int WATCH_DIV = `CGC_MAIN_FREQ_HZ / `CGC_PLL_MULT / `CGC_WATCH_FREQ_HZ
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [`CGC_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_bit_wr,
    input wire logic [2:0] i_bit_sel,
    input wire logic i_bit_val,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Power modes and subclock
    input wire logic i_stop_mode,
    input wire logic i_idle_mode,
    input wire logic i_sub_tick,
    input wire logic i_wait_access,
    input wire logic i_clock_output_pin_en,
    // Oscillator and PLL controls
    output logic o_main_osc_en,
    output logic o_sub_fb_disable,
    output logic o_main_fb_disable,
    output logic o_pll_run,
    output logic o_pll_mult4,
    // Generated clocks as tick enables, clock pin level and CPU stall flag
    output logic [`CGC_PRE1_STAGES-1:0] o_periph_tick,
    output logic o_sys_tick,
    output logic o_cpu_tick,
    output logic o_watch_tick,
    output logic o_clock_output_pin,
    output logic o_cpu_stall
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic div_tick(input logic [`CGC_PRE_CNT_W-1:0] cnt,
                                      input logic [3:0] k);
        logic [`CGC_PRE_CNT_W-1:0] mask;
        mask = `CGC_PRE_CNT_W'((11'h1 << k) - 11'h1);
        div_tick = ((cnt & mask) == mask);
    endfunction : div_tick

    function automatic logic [2:0] sel_ratio(input logic [2:0] sel);
        // Prohibited codes fall back to the slowest ratio
        sel_ratio = (sel > `CGC_DIV_MAX_SEL) ? `CGC_DIV_MAX_SEL : sel;
    endfunction : sel_ratio

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    logic [7:0] pcc_ff;
    logic [7:0] nxt_pcc;
    logic [7:0] pll_ctrl_ff;
    logic [7:0] nxt_pll_ctrl;
    logic prot_armed_ff;
    clock_generator_control_pkg::clk_src_type src_ff;
    clock_generator_control_pkg::clk_src_type nxt_src;
    logic [`CGC_PRE_CNT_W-1:0] pre_cnt_ff;
    logic [1:0] pll_phase_ff;
    logic [15:0] watch_cnt_ff;
    logic clock_output_pin_ff;
    logic stall_ff;

    logic on_sub;
    logic main_running;
    logic sys_stopped;
    logic osc_tick;
    logic sel_tick;
    logic pcc_hit;
    logic pll_hit;
    logic pcc_write;
    logic pll_write;
    logic [7:0] wr_val_pcc;
    logic [7:0] wr_val_pll;

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    assign pcc_hit = (i_addr == `CGC_ADDR_PROC_CLK_CTRL);
    assign pll_hit = (i_addr == `CGC_ADDR_PLL_CONTROL);
    assign pcc_write = (i_wr | i_bit_wr) & pcc_hit & prot_armed_ff;
    assign pll_write = (i_wr | i_bit_wr) & pll_hit;

    always_comb begin
        wr_val_pcc = pcc_ff;
        wr_val_pll = pll_ctrl_ff;
        if (i_bit_wr) begin
            wr_val_pcc[i_bit_sel] = i_bit_val;
            wr_val_pll[i_bit_sel] = i_bit_val;
        end else begin
            wr_val_pcc = i_wdata;
            wr_val_pll = i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            prot_armed_ff <= 1'b0;
        end else if (i_wr | i_bit_wr | i_rd) begin
            prot_armed_ff <= i_wr & (i_addr == `CGC_ADDR_PROTECTION_CMD);
        end
    end

    always_comb begin
        nxt_pcc = pcc_ff;
        if (pcc_write) begin
            nxt_pcc = wr_val_pcc;
        end
        nxt_pcc[`CGC_BIT_CPU_STATUS] = on_sub;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pcc_ff <= `CGC_PCC_RESET;
        end else begin
            pcc_ff <= nxt_pcc;
        end
    end

    always_comb begin
        nxt_pll_ctrl = pll_ctrl_ff;
        if (pll_write) begin
            nxt_pll_ctrl = {6'h00, wr_val_pll[`CGC_BIT_PLL_MODE:0]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pll_ctrl_ff <= `CGC_PLL_RESET;
        end else begin
            pll_ctrl_ff <= nxt_pll_ctrl;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd & pcc_hit) begin
            o_rdata <= pcc_ff;
        end else if (i_rd & pll_hit) begin
            o_rdata <= pll_ctrl_ff;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // CPU clock source switching
    // ----------------------------------------------------------------
    assign on_sub = (src_ff == clock_generator_control_pkg::SRC_SUB) |
                    (src_ff == clock_generator_control_pkg::SRC_TO_MAIN);

    always_comb begin
        nxt_src = src_ff;
        case (src_ff)
            clock_generator_control_pkg::SRC_MAIN: begin
                if (pcc_ff[`CGC_BIT_SEL_TOP]) begin
                    nxt_src = clock_generator_control_pkg::SRC_TO_SUB;
                end
            end
            clock_generator_control_pkg::SRC_TO_SUB: begin
                if (!pcc_ff[`CGC_BIT_SEL_TOP]) begin
                    nxt_src = clock_generator_control_pkg::SRC_MAIN;
                end else if (i_sub_tick) begin
                    nxt_src = clock_generator_control_pkg::SRC_SUB;
                end
            end
            clock_generator_control_pkg::SRC_SUB: begin
                if (!pcc_ff[`CGC_BIT_SEL_TOP]) begin
                    nxt_src = clock_generator_control_pkg::SRC_TO_MAIN;
                end
            end
            clock_generator_control_pkg::SRC_TO_MAIN: begin
                if (pcc_ff[`CGC_BIT_SEL_TOP]) begin
                    nxt_src = clock_generator_control_pkg::SRC_SUB;
                end else if (i_sub_tick) begin
                    nxt_src = clock_generator_control_pkg::SRC_MAIN;
                end
            end
            default: begin
                nxt_src = clock_generator_control_pkg::SRC_MAIN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            src_ff <= clock_generator_control_pkg::SRC_MAIN;
        end else begin
            src_ff <= nxt_src;
        end
    end

    // ----------------------------------------------------------------
    // Oscillator controls
    // ----------------------------------------------------------------
    // stop only once on subclock
    assign main_running = !i_stop_mode & !(pcc_ff[`CGC_BIT_MAIN_OSC_STOP] & on_sub);
    assign sys_stopped = i_stop_mode | i_idle_mode;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_main_osc_en <= 1'b1;
        end else begin
            o_main_osc_en <= main_running;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_sub_fb_disable <= 1'b0;
        end else begin
            o_sub_fb_disable <= pcc_ff[`CGC_BIT_SUB_FB_DIS];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_main_fb_disable <= 1'b0;
        end else begin
            o_main_fb_disable <= pcc_ff[`CGC_BIT_MAIN_FB_DIS];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pll_run <= 1'b1;
        end else begin
            o_pll_run <= pll_ctrl_ff[`CGC_BIT_PLL_RUN];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pll_mult4 <= 1'b0;
        end else begin
            o_pll_mult4 <= pll_ctrl_ff[`CGC_BIT_PLL_RUN] & pll_ctrl_ff[`CGC_BIT_PLL_MODE];
        end
    end

    // ----------------------------------------------------------------
    // PLL and interval divider
    // ----------------------------------------------------------------
    // one oscillator tick per four main cycles when multiplying
    assign osc_tick = main_running & (!o_pll_mult4 | (pll_phase_ff == 2'(`CGC_PLL_MULT - 1)));

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pll_phase_ff <= 2'h0;
        end else begin
            pll_phase_ff <= pll_phase_ff + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            watch_cnt_ff <= 16'h0000;
            o_watch_tick <= 1'b0;
        end else begin
            o_watch_tick <= 1'b0;
            if (osc_tick) begin
                if (watch_cnt_ff == 16'(WATCH_DIV - 1)) begin
                    watch_cnt_ff <= 16'h0000;
                    o_watch_tick <= 1'b1;
                end else begin
                    watch_cnt_ff <= watch_cnt_ff + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Prescalers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pre_cnt_ff <= '0;
        end else if (main_running) begin
            pre_cnt_ff <= pre_cnt_ff + `CGC_PRE_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_periph_tick <= '0;
        end else begin
            for (int k = 0; k < `CGC_PRE1_STAGES; k++) begin
                o_periph_tick[k] <= main_running & !sys_stopped &
                                    div_tick(pre_cnt_ff, 4'(k));
            end
        end
    end

    assign sel_tick = on_sub ? i_sub_tick :
                      (main_running &
                       div_tick(pre_cnt_ff, {1'b0, sel_ratio(pcc_ff[`CGC_SEL_DIV_HI:0])}));

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_sys_tick <= 1'b0;
            o_cpu_tick <= 1'b0;
        end else begin
            o_sys_tick <= sel_tick & !sys_stopped;
            o_cpu_tick <= sel_tick & !sys_stopped & !stall_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            clock_output_pin_ff <= 1'b0;
        end else if (!i_clock_output_pin_en | sys_stopped) begin
            clock_output_pin_ff <= 1'b0;
        end else if (sel_tick) begin
            clock_output_pin_ff <= !clock_output_pin_ff;
        end
    end

    assign o_clock_output_pin = clock_output_pin_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            stall_ff <= 1'b0;
        end else if (on_sub & !main_running & i_wait_access) begin
            stall_ff <= 1'b1;
        end
    end

    assign o_cpu_stall = stall_ff;

endmodule : clock_generator_control

// ==== verilog/clock_generator_control_cfg.svh ====
// Offsets, reset values, field positions and timing figures of the clock generator
`ifndef CLOCK_GENERATOR_CONTROL_CFG_SVH
`define CLOCK_GENERATOR_CONTROL_CFG_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define CGC_ADDR_W 28
`define CGC_ADDR_PROC_CLK_CTRL 28'hffff828
`define CGC_ADDR_PLL_CONTROL 28'hffff82c
`define CGC_ADDR_PROTECTION_CMD 28'hffff1fc

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CGC_PCC_RESET 8'h03
`define CGC_PLL_RESET 8'h01

// ----------------------------------------------------------------
// Processor clock control fields
// ----------------------------------------------------------------
`define CGC_BIT_SUB_FB_DIS 7
`define CGC_BIT_MAIN_OSC_STOP 6
`define CGC_BIT_MAIN_FB_DIS 5
`define CGC_BIT_CPU_STATUS 4
`define CGC_BIT_SEL_TOP 3
`define CGC_SEL_DIV_HI 2
`define CGC_DIV_MAX_SEL 3'h5

// ----------------------------------------------------------------
// PLL control fields
// ----------------------------------------------------------------
`define CGC_BIT_PLL_MODE 1
`define CGC_BIT_PLL_RUN 0
`define CGC_PLL_MULT 4

// ----------------------------------------------------------------
// Prescalers and timing
// ----------------------------------------------------------------
`define CGC_PRE1_STAGES 11
`define CGC_PRE_CNT_W 10
`define CGC_WATCH_FREQ_HZ 32768
`define CGC_MAIN_FREQ_HZ 20000000

`endif

// ==== verilog/clock_generator_control_pkg.sv ====
// Types shared by the clock generator
package clock_generator_control_pkg;

    // ----------------------------------------------------------------
    // CPU clock source states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_MAIN,
        SRC_TO_SUB,
        SRC_SUB,
        SRC_TO_MAIN
    } clk_src_type;

endpackage : clock_generator_control_pkg

// ==== verif/clock_generator_control_properties.sv ====
// Port-level checks for the clock generator
`timescale 1ns/1ps
module clock_generator_control_properties #(
    parameter int WATCH_DIV = 4
) (
    // Inputs watched
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_rd,
    input wire logic i_stop_mode,
    input wire logic i_idle_mode,
    input wire logic i_clock_output_pin_en,
    // Outputs watched
    input wire logic [7:0] o_rdata,
    input wire logic o_main_osc_en,
    input wire logic o_sub_fb_disable,
    input wire logic o_main_fb_disable,
    input wire logic o_pll_run,
    input wire logic o_pll_mult4,
    input wire logic [10:0] o_periph_tick,
    input wire logic o_sys_tick,
    input wire logic o_cpu_tick,
    input wire logic o_watch_tick,
    input wire logic o_clock_output_pin,
    input wire logic o_cpu_stall
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // ------------------------------------------------------------
    // Watch tick spacing counter
    // ------------------------------------------------------------
    logic [15:0] wgap_ff;
    logic wseen_ff;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || o_watch_tick) begin
            wgap_ff <= 16'h0000;
        end else if (wgap_ff != 16'hffff) begin
            wgap_ff <= wgap_ff + 16'h0001;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wseen_ff <= 1'b0;
        end else if (o_watch_tick) begin
            wseen_ff <= 1'b1;
        end
    end

    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    property p_reset_vals;
        $past(i_sys_rst) |-> o_main_osc_en && o_pll_run && !o_pll_mult4
            && !o_sub_fb_disable && !o_main_fb_disable && !o_cpu_stall;
    endproperty
    property p_mult4_run;
        o_pll_mult4 |-> o_pll_run;
    endproperty
    property p_stall_hold;
        o_cpu_stall |=> o_cpu_stall && !o_cpu_tick;
    endproperty
    property p_cpu_from_sys;
        o_cpu_tick |-> o_sys_tick;
    endproperty
    property p_periph_top;
        o_periph_tick[10] |=> !o_periph_tick[10] [*8];
    endproperty
    property p_stop_osc;
        i_stop_mode [*2] |-> !o_main_osc_en;
    endproperty
    property p_pin_low;
        (!i_clock_output_pin_en || i_stop_mode || i_idle_mode) [*2] |-> !o_clock_output_pin;
    endproperty
    property p_sys_halt;
        (i_stop_mode || i_idle_mode) [*2] |-> !o_sys_tick;
    endproperty
    property p_watch_gap;
        o_watch_tick && wseen_ff |-> wgap_ff >= 16'(WATCH_DIV - 1);
    endproperty

    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
    a_mult4_run: assert property (p_mult4_run) else $error("multiply without run");
    a_stall_hold: assert property (p_stall_hold) else $error("stall released");
    a_cpu_from_sys: assert property (p_cpu_from_sys) else $error("cpu tick alone");
    a_periph_top: assert property (p_periph_top) else $error("divide 1024 too fast");
    a_stop_osc: assert property (p_stop_osc) else $error("osc runs in stop");
    a_pin_low: assert property (p_pin_low) else $error("clock pin not low");
    a_sys_halt: assert property (p_sys_halt) else $error("system tick in halt");
    a_watch_gap: assert property (p_watch_gap) else $error("watch tick too early");

    c_stall: cover property (o_cpu_stall);
    c_mult4: cover property (o_pll_mult4 && o_watch_tick);
    c_read: cover property ($past(i_rd) && o_rdata != 8'h00);
endmodule : clock_generator_control_properties

// ==== verif/sub_osc_model.sv ====
// Subclock oscillator model: one tick per subclock period
`timescale 1ns/1ps
module sub_osc_model #(
    parameter int PERIOD = 40
) (
    input wire logic i_clk,
    output logic o_sub_tick
);
    int cnt = 0;
    initial o_sub_tick = 1'b0;
    // Free running in every mode
    always @(posedge i_clk) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        o_sub_tick <= (cnt == PERIOD - 1);
    end
endmodule : sub_osc_model

// ==== verif/clock_generator_control_tb_top.sv ====
// Self-checking bench for the clock generator
`timescale 1ns/1ps
`include "clock_generator_control_cfg.svh"
module clock_generator_control_tb_top;
    typedef struct {logic [7:0] d; logic [7:0] per;} row_type;
    row_type rows[8] = '{'{8'h00, 8'h01}, '{8'ha1, 8'h02}, '{8'h22, 8'h04}, '{8'h83, 8'h08},
        '{8'h04, 8'h10}, '{8'h05, 8'h20}, '{8'h06, 8'h20}, '{8'h07, 8'h20}};
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_bit_wr = 1'b0, i_bit_val = 1'b0;
    logic i_rd = 1'b0, i_stop_mode = 1'b0, i_idle_mode = 1'b0, i_wait_access = 1'b0;
    logic i_clock_output_pin_en = 1'b0, i_sub_tick, o_main_osc_en, o_sub_fb_disable, o_main_fb_disable;
    logic [`CGC_ADDR_W-1:0] i_addr = '0;
    logic [7:0] i_wdata = 8'h00, o_rdata, d, n;
    logic [2:0] i_bit_sel = 3'h0;
    logic o_pll_run, o_pll_mult4, o_sys_tick, o_cpu_tick, o_watch_tick, o_clock_output_pin;
    logic o_cpu_stall, pin_q = 1'b0;
    logic [10:0] o_periph_tick;
    int miscompares = 0, n_compared = 0, pc = 0, wc = 0, tg = 0, ct = 0, x, k;

    clock_generator_control #(.WATCH_DIV(4)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_bit_wr(i_bit_wr),
        .i_bit_sel(i_bit_sel), .i_bit_val(i_bit_val), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_stop_mode(i_stop_mode), .i_idle_mode(i_idle_mode), .i_sub_tick(i_sub_tick),
        .i_wait_access(i_wait_access), .i_clock_output_pin_en(i_clock_output_pin_en),
        .o_main_osc_en(o_main_osc_en), .o_sub_fb_disable(o_sub_fb_disable),
        .o_main_fb_disable(o_main_fb_disable), .o_pll_run(o_pll_run),
        .o_pll_mult4(o_pll_mult4), .o_periph_tick(o_periph_tick), .o_sys_tick(o_sys_tick),
        .o_cpu_tick(o_cpu_tick), .o_watch_tick(o_watch_tick),
        .o_clock_output_pin(o_clock_output_pin), .o_cpu_stall(o_cpu_stall));
    sub_osc_model #(.PERIOD(40)) u_sub (.i_clk(i_clk), .o_sub_tick(i_sub_tick));

    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        pc <= pc + int'(o_periph_tick[10] === 1'b1);
        wc <= wc + int'(o_watch_tick === 1'b1);
        ct <= ct + int'(o_cpu_tick === 1'b1);
        tg <= tg + int'(o_clock_output_pin !== pin_q);
        pin_q <= o_clock_output_pin;
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [27:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [27:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd
    task automatic pwr(input logic [7:0] v);
        wr(`CGC_ADDR_PROTECTION_CMD, 8'h00);
        wr(`CGC_ADDR_PROC_CLK_CTRL, v);
    endtask : pwr
    task automatic bwr(input logic v);
        wr(`CGC_ADDR_PROTECTION_CMD, 8'h00);
        @(posedge i_clk);
        i_addr <= `CGC_ADDR_PROC_CLK_CTRL;
        i_bit_sel <= 3'h3;
        i_bit_val <= v;
        i_bit_wr <= 1'b1;
        @(posedge i_clk);
        i_bit_wr <= 1'b0;
    endtask : bwr
    task automatic poll(input logic s);
        k = 0;
        do begin
            rd(`CGC_ADDR_PROC_CLK_CTRL);
            k++;
        end while (d[4] !== s && k < 40);
    endtask : poll
    task automatic period;
        @(posedge i_clk);
        repeat (3) begin
            n = 8'h00;
            do begin
                @(posedge i_clk);
                #1;
                n++;
            end while (o_sys_tick !== 1'b1 && n < 8'h64);
        end
    endtask : period
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        #(50 * 30000);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(`CGC_ADDR_PROC_CLK_CTRL);
        chk(d, 8'h03);
        rd(`CGC_ADDR_PLL_CONTROL);
        chk(d, 8'h01);
        wr(`CGC_ADDR_PROC_CLK_CTRL, 8'h00);
        rd(`CGC_ADDR_PROC_CLK_CTRL);
        chk(d, 8'h03);
        wr(`CGC_ADDR_PROTECTION_CMD, 8'h00);
        rd(28'h0000100);
        chk(d, 8'h00);
        wr(`CGC_ADDR_PROC_CLK_CTRL, 8'h00);
        rd(`CGC_ADDR_PROC_CLK_CTRL);
        chk(d, 8'h03);
        pwr(8'h13);
        rd(`CGC_ADDR_PROC_CLK_CTRL);
        chk(d, 8'h03);
        $display("register access test done");
        foreach (rows[i]) begin
            pwr(rows[i].d);
            rd(`CGC_ADDR_PROC_CLK_CTRL);
            chk(d, rows[i].d);
            chk({6'h00, o_sub_fb_disable, o_main_fb_disable},
                {6'h00, rows[i].d[7], rows[i].d[5]});
            period();
            chk(n, rows[i].per);
            chk({7'h00, o_cpu_tick}, 8'h01);
        end
        $display("divider table test done");
        x = pc;
        repeat (2048) @(posedge i_clk);
        #1;
        chk(8'(pc - x), 8'h02);
        x = wc;
        repeat (40) @(posedge i_clk);
        #1;
        chk(8'(wc - x), 8'h0a);
        wr(`CGC_ADDR_PLL_CONTROL, 8'hff);
        rd(`CGC_ADDR_PLL_CONTROL);
        chk(d, 8'h03);
        x = wc;
        repeat (160) @(posedge i_clk);
        #1;
        chk(8'(wc - x), 8'h0a);
        wr(`CGC_ADDR_PLL_CONTROL, 8'h00);
        repeat (2) @(posedge i_clk);
        chk({6'h00, o_pll_run, o_pll_mult4}, 8'h00);
        wr(`CGC_ADDR_PLL_CONTROL, 8'h01);
        $display("prescaler and pll test done");
        pwr(8'h43);
        i_clock_output_pin_en <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        x = tg;
        repeat (40) @(posedge i_clk);
        #1;
        chk(8'(tg - x), 8'h05);
        chk({7'h00, o_main_osc_en}, 8'h01);
        i_clock_output_pin_en <= 1'b0;
        bwr(1'b1);
        poll(1'b1);
        chk({7'h00, k < 23}, 8'h01);
        repeat (3) @(posedge i_clk);
        chk({7'h00, o_main_osc_en}, 8'h00);
        i_wait_access <= 1'b1;
        @(posedge i_clk);
        i_wait_access <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk({7'h00, o_cpu_stall}, 8'h01);
        pwr(8'h0b);
        x = ct;
        repeat (50) @(posedge i_clk);
        #1;
        chk(8'(ct - x), 8'h00);
        bwr(1'b0);
        poll(1'b0);
        chk({7'h00, k < 23}, 8'h01);
        chk(d, 8'h03);
        $display("subclock switch test done");
        i_stop_mode <= 1'b1;
        repeat (5) @(posedge i_clk);
        chk({6'h00, o_main_osc_en, o_sys_tick}, 8'h00);
        i_stop_mode <= 1'b0;
        i_idle_mode <= 1'b1;
        i_clock_output_pin_en <= 1'b1;
        repeat (5) @(posedge i_clk);
        chk({6'h00, o_main_osc_en, o_clock_output_pin}, 8'h02);
        i_idle_mode <= 1'b0;
        i_clock_output_pin_en <= 1'b0;
        i_sys_rst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        chk({7'h00, o_cpu_stall}, 8'h00);
        $display("power mode and reset test done");
        complete_run();
    end
endmodule : clock_generator_control_tb_top

bind clock_generator_control clock_generator_control_properties #(.WATCH_DIV(WATCH_DIV))
    u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rd(i_rd), .i_stop_mode(i_stop_mode),
    .i_idle_mode(i_idle_mode), .i_clock_output_pin_en(i_clock_output_pin_en), .o_rdata(o_rdata),
    .o_main_osc_en(o_main_osc_en), .o_sub_fb_disable(o_sub_fb_disable),
    .o_main_fb_disable(o_main_fb_disable), .o_pll_run(o_pll_run),
    .o_pll_mult4(o_pll_mult4), .o_periph_tick(o_periph_tick), .o_sys_tick(o_sys_tick),
    .o_cpu_tick(o_cpu_tick), .o_watch_tick(o_watch_tick),
    .o_clock_output_pin(o_clock_output_pin), .o_cpu_stall(o_cpu_stall));
